/* File: driver_fault_supervisor.sv */
// fault supervision, latched flags, fault pin and output gating
//
// Behaviour
// - fault pin low while any fault present
// - pin released after clean power-up
// - supply lockout: bridges off, pump off
// - supply lockout sets summary; lockout flag only after power-up
// - supply recovery clears summary; lockout flag latched
// - core reset: flags low, pin released
// - power-up: summary set until supply rises
// - pump low: bridges off, flags set
// - pump recovers: resume; pump flag latched
// - qualified overcurrent disables bridge, latches flags
// - per FET short flags, supply/ground side
// - latched mode holds until clear
// - retry mode resumes after wait, condition gone
// - open winding qualified by time, when enabled
// - open winding sets summary, per-winding flags
// - open winding clears only on clear event
`timescale 1ns/10ps
module driver_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned OPEN_DET_CYCLES = OPEN_DET_CYC,
  parameter int unsigned OCP_CYCLES = OCP_QUAL_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // supply below the core reset level: digital core held in reset
  input wire logic i_core_rst,
  // comparator with hysteresis: high below falling, low above rising
  input wire logic i_supply_low,
  input wire logic i_pump_low,
  input wire fet_limit_s i_fet_limit,
  // per winding: current below both open threshold and trip level
  input wire logic [NUM_BRIDGES-1:0] i_winding_low,
  input wire logic i_open_winding_detect_enable,
  input wire logic i_overcurrent_recovery_select,
  input wire logic i_clear_faults_cmd,
  input wire logic i_sleep_n_input,
  input wire logic i_fault_out_n_in,
  // open-drain pin: value fixed low, enable low while sinking
  output logic o_fault_out_n,
  output logic o_fault_out_n_oe,
  // wired line seen low, one cycle late
  output logic o_fault_line_low,
  output fault_flags_s o_flags,
  output logic [NUM_BRIDGES-1:0] o_bridge_enable,
  output logic o_pump_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    // power-up phase: summary set, lockout flag held off
    logic powerup;
    logic sleep_d;
    fault_flags_s flags;
    logic [NUM_BRIDGES-1:0] trip;
    logic [NUM_BRIDGES-1:0] open_hold;
    logic pin_oe;
    logic line_low;
    logic [NUM_BRIDGES-1:0] bridge_en;
    logic pump_en;
  } sup_s;

  sup_s st_r;
  sup_s st_nxt;

  // the core reset wins over everything
  logic core_reset;
  assign core_reset = i_sys_rst | i_core_rst;

  ////////////////////////////////////////////////////////////////////////////
  // clear events and stage gating

  logic sleep_exit;
  logic clear_evt;
  logic retry_mode;
  logic stage_block;

  // rising sleep input ends a reset pulse or a sleep period
  assign sleep_exit = i_sleep_n_input & ~st_r.sleep_d;
  // single-cycle clear, nothing to self-clear in a register
  // a held command simply clears again on every cycle it stays high
  assign clear_evt = i_clear_faults_cmd | sleep_exit;
  // only the retry setting lets the timer release a trip
  assign retry_mode = (i_overcurrent_recovery_select == OVERCURRENT_RECOVERY_SELECT_RETRY);
  // lockout or pump low stops every bridge
  // sleep stops the stage too but leaves every flag as it was
  assign stage_block = i_supply_low | i_pump_low | ~i_sleep_n_input;

  ////////////////////////////////////////////////////////////////////////////
  // qualification of current limit and open winding

  logic [NUM_OUTPUTS-1:0] hs_qual;
  logic [NUM_OUTPUTS-1:0] ls_qual;
  logic [NUM_BRIDGES-1:0] open_qual;
  logic [NUM_BRIDGES-1:0] retry_done;
  logic [NUM_BRIDGES-1:0] trip_start;
  logic [NUM_BRIDGES-1:0] bridge_limit;
  logic [NUM_BRIDGES-1:0] bridge_qual;

  // one filter per FET, so a short names its own output
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_fet
      persist_filter #(.LIMIT(OCP_CYCLES)) u_hs_filt (
        .i_mclk(i_mclk),
        .i_sys_rst(core_reset),
        .i_cond(i_fet_limit.high_side[g]),
        .o_qualified(hs_qual[g])
      );
      // supply short side of the same output
      persist_filter #(.LIMIT(OCP_CYCLES)) u_ls_filt (
        .i_mclk(i_mclk),
        .i_sys_rst(core_reset),
        .i_cond(i_fet_limit.low_side[g]),
        .o_qualified(ls_qual[g])
      );
    end

    for (g = 0; g < NUM_BRIDGES; g++) begin : g_bridge
      localparam int unsigned LO = g * OUTS_PER_BRIDGE;
      // raw limits of both outputs of this bridge
      assign bridge_limit[g] = |{i_fet_limit.high_side[LO +: OUTS_PER_BRIDGE],
                                 i_fet_limit.low_side[LO +: OUTS_PER_BRIDGE]};
      assign bridge_qual[g] = |{hs_qual[LO +: OUTS_PER_BRIDGE], ls_qual[LO +: OUTS_PER_BRIDGE]};
      // a new qualification restarts the wait even while tripped
      assign trip_start[g] = bridge_qual[g];

      retry_timer #(.LIMIT(RETRY_CYCLES)) u_retry (
        .i_mclk(i_mclk),
        .i_sys_rst(core_reset),
        .i_start(trip_start[g]),
        .o_elapsed(retry_done[g])
      );

      persist_filter #(.LIMIT(OPEN_DET_CYCLES)) u_open_filt (
        .i_mclk(i_mclk),
        .i_sys_rst(core_reset),
        .i_cond(i_winding_low[g] & i_open_winding_detect_enable),
        .o_qualified(open_qual[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic oc_any_limit;

  // every set below follows its clear, so a cause still present wins
  always_comb begin
    st_nxt = st_r;
    st_nxt.sleep_d = i_sleep_n_input;
    oc_any_limit = |bridge_limit;

    // power-up phase ends once the supply has risen
    // lockout flag stays low while the supply first climbs
    if (!i_supply_low) begin
      st_nxt.powerup = 1'b0;
    end

    // lockout flag cleared only by clear event with supply good
    if (clear_evt && !i_supply_low) begin
      st_nxt.flags.supply_low_lockout_flag = 1'b0;
    end
    // lockout flag set wins over clear; not during power-up
    if (i_supply_low && !st_r.powerup) begin
      st_nxt.flags.supply_low_lockout_flag = 1'b1;
    end

    // pump flag latched until clear with pump good
    if (clear_evt && !i_pump_low) begin
      st_nxt.flags.pump_low_flag = 1'b0;
    end
    if (i_pump_low) begin
      st_nxt.flags.pump_low_flag = 1'b1;
    end

    // short flags clear per FET only when its limit is gone
    for (int k = 0; k < NUM_OUTPUTS; k++) begin
      if (clear_evt && !i_fet_limit.high_side[k]) begin
        st_nxt.flags.highside_short_flag[k] = 1'b0;
      end
      if (clear_evt && !i_fet_limit.low_side[k]) begin
        st_nxt.flags.lowside_short_flag[k] = 1'b0;
      end
      // ground short trips high side, supply short low side
      if (hs_qual[k]) begin
        st_nxt.flags.highside_short_flag[k] = 1'b1;
      end
      if (ls_qual[k]) begin
        st_nxt.flags.lowside_short_flag[k] = 1'b1;
      end
    end

    // overcurrent flag cleared by clear event once no limit is active
    if (clear_evt && !oc_any_limit) begin
      st_nxt.flags.overcurrent_flag = 1'b0;
    end
    if (|bridge_qual) begin
      st_nxt.flags.overcurrent_flag = 1'b1;
    end

    for (int b = 0; b < NUM_BRIDGES; b++) begin
      // latched trip released by clear with limit gone
      if (clear_evt && !bridge_limit[b]) begin
        st_nxt.trip[b] = 1'b0;
      end
      // retry release after the wait, limit gone
      if (retry_mode && retry_done[b]
          && !bridge_limit[b]) begin
        st_nxt.trip[b] = 1'b0;
      end
      if (bridge_qual[b]) begin
        st_nxt.trip[b] = 1'b1;
      end

      // open hold needs condition gone and a clear event
      if (clear_evt && !open_qual[b]) begin
        st_nxt.open_hold[b] = 1'b0;
      end
      if (open_qual[b]) begin
        st_nxt.open_hold[b] = 1'b1;
      end
    end

    // per winding flags follow their holds
    st_nxt.flags.open_winding_a_flag = st_nxt.open_hold[0];
    st_nxt.flags.open_winding_b_flag = st_nxt.open_hold[1];
    st_nxt.flags.open_winding_flag = |st_nxt.open_hold;

    // summary follows the active faults only
    // latched causes reach it through the trip and open holds
    st_nxt.flags.summary_fault_flag = i_supply_low
                                      | i_pump_low
                                      | (|st_nxt.trip)
                                      | (|st_nxt.open_hold);

    // pin driven exactly with the summary flag
    st_nxt.pin_oe = ~st_nxt.flags.summary_fault_flag;

    // bridges off on lockout, pump low or own trip
    for (int b = 0; b < NUM_BRIDGES; b++) begin
      st_nxt.bridge_en[b] = ~stage_block & ~st_nxt.trip[b];
    end
    // pump off in supply lockout or sleep; pump low keeps it running
    st_nxt.pump_en = ~i_supply_low & i_sleep_n_input;

    // wired line may be pulled low by other devices too
    st_nxt.line_low = ~i_fault_out_n_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_mclk) begin
    if (core_reset) begin
      // flags low and pin released under core reset
      // a power cycle drops every latched trip
      st_r.powerup <= 1'b1;
      // sleep input already high when reset ends must not count as an exit
      st_r.sleep_d <= 1'b1;
      st_r.flags <= FLAGS_RESET;
      st_r.trip <= '0;
      st_r.open_hold <= '0;
      st_r.pin_oe <= FAULT_PIN_RELEASED;
      st_r.line_low <= 1'b0;
      st_r.bridge_en <= '0;
      st_r.pump_en <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // released (oe high) after a clean power-up
  // open drain: the pin only sinks, the enable does the work
  assign o_fault_out_n = FAULT_PIN_LOW;
  assign o_fault_out_n_oe = st_r.pin_oe;
  assign o_fault_line_low = st_r.line_low;
  assign o_flags = st_r.flags;
  assign o_bridge_enable = st_r.bridge_en;
  assign o_pump_enable = st_r.pump_en;

endmodule : driver_fault_supervisor

/* File: fault_sup_pkg.sv */
// shared constants and carrier types of the driver fault supervisor
package fault_sup_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  // overcurrent qualification time, a least time: rounds up
  localparam int unsigned OCP_QUAL_NS = 2000;
  localparam int unsigned OCP_QUAL_CYC = (OCP_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // automatic retry wait, a least time: rounds up
  localparam int unsigned RETRY_NS = 4000000;
  localparam int unsigned RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // open winding detection time, a least time: rounds up
  localparam int unsigned OPEN_DET_NS = 5000000;
  localparam int unsigned OPEN_DET_CYC = (OPEN_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // structure of the power stage
  localparam int unsigned NUM_OUTPUTS = 4;
  localparam int unsigned NUM_BRIDGES = 2;
  localparam int unsigned OUTS_PER_BRIDGE = 2;

  // recovery selection encodings
  localparam logic OVERCURRENT_RECOVERY_SELECT_LATCHED = 1'h0;
  localparam logic OVERCURRENT_RECOVERY_SELECT_RETRY = 1'h1;

  // fault pin values: released level at reset, sinking level
  localparam logic FAULT_PIN_RELEASED = 1'h1;
  localparam logic FAULT_PIN_LOW = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // per output current limit, index 0/1 bridge a out1/out2, 2/3 bridge b
  typedef struct packed {
    logic [NUM_OUTPUTS-1:0] high_side;
    logic [NUM_OUTPUTS-1:0] low_side;
  } fet_limit_s;

  // status flags seen by the serial port
  typedef struct packed {
    logic summary_fault_flag;
    logic supply_low_lockout_flag;
    logic pump_low_flag;
    logic overcurrent_flag;
    logic [NUM_OUTPUTS-1:0] highside_short_flag;
    logic [NUM_OUTPUTS-1:0] lowside_short_flag;
    logic open_winding_flag;
    logic open_winding_a_flag;
    logic open_winding_b_flag;
  } fault_flags_s;

  localparam fault_flags_s FLAGS_RESET = '0;

endpackage : fault_sup_pkg

/* File: persist_filter.sv */
// qualifies a condition that persists longer than a count of cycles
`timescale 1ns/10ps
module persist_filter
  import fault_sup_pkg::*;
#(
  parameter int unsigned LIMIT = OCP_QUAL_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_cond,
  output logic o_qualified
);

  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic qual;
  } filt_s;

  filt_s st_r;
  filt_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!i_cond) begin
      // any gap restarts the qualification
      st_nxt.cnt = '0;
      st_nxt.qual = 1'b0;
    end else if (st_r.cnt != LIMIT_C) begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end else begin
      st_nxt.qual = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_qualified = st_r.qual;

endmodule : persist_filter

/* File: retry_timer.sv */
// one-shot wait started by a pulse, elapsed level held until next start
`timescale 1ns/10ps
module retry_timer
  import fault_sup_pkg::*;
#(
  parameter int unsigned LIMIT = RETRY_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  output logic o_elapsed
);

  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic run;
    logic done;
  } tmr_s;

  tmr_s st_r;
  tmr_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_start) begin
      st_nxt.cnt = '0;
      st_nxt.run = 1'b1;
      st_nxt.done = 1'b0;
    end else if (st_r.run) begin
      if (st_r.cnt == LIMIT_C - CW'(1)) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_elapsed = st_r.done;

endmodule : retry_timer

/* File: host_ctrl_model.sv */
// host side: pulled-up fault line, clear pulses and sleep pulses
`timescale 1ns/10ps
module host_ctrl_model (
  input wire logic i_mclk,
  input wire logic i_fault_out_n,
  input wire logic i_fault_out_n_oe,
  input wire logic i_clear_req,
  input wire logic i_sleep_req,
  output logic o_fault_line,
  output logic o_clear_faults_cmd,
  output logic o_sleep_n_input
);
  logic clear_r = 1'h0;
  logic sleep_n_r = 1'h1;
  logic [1:0] sleep_cnt_r = 2'h0;
  // pull-up wins unless the device sinks the line
  assign o_fault_line = (!i_fault_out_n_oe && !i_fault_out_n) ? 1'h0 : 1'h1;
  assign o_clear_faults_cmd = clear_r;
  assign o_sleep_n_input = sleep_n_r;
  always @(posedge i_mclk) begin
    clear_r <= i_clear_req;
    if (i_sleep_req) begin
      sleep_cnt_r <= 2'h2;
    end else if (sleep_cnt_r != 2'h0) begin
      sleep_cnt_r <= sleep_cnt_r - 2'h1;
    end
    sleep_n_r <= (sleep_cnt_r == 2'h0) && !i_sleep_req;
  end
endmodule : host_ctrl_model

/* File: driver_fault_supervisor_assertions.sv */
// port-level checks of the fault supervisor
`timescale 1ns/10ps
module driver_fault_supervisor_checker
  import fault_sup_pkg::*;
#(
  parameter int unsigned OCP_CYCLES = OCP_QUAL_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_core_rst,
  input wire logic i_supply_low,
  input wire logic i_pump_low,
  input wire fet_limit_s i_fet_limit,
  input wire logic i_clear_faults_cmd,
  input wire logic i_sleep_n_input,
  input wire logic o_fault_out_n_oe,
  input wire fault_flags_s o_flags,
  input wire logic [NUM_BRIDGES-1:0] o_bridge_enable,
  input wire logic o_pump_enable
);
  typedef struct packed {
    logic powerup;
    logic [7:0] limit_run;
  } chk_state_s;
  chk_state_s st_r;
  chk_state_s st_nxt;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst || i_core_rst);
  ////////////////////////////////////////////////////////////////////////////
  // saturating run of out0 high-side limit; power-up phase tracker
  always_comb begin
    st_nxt = st_r;
    if (!i_supply_low) begin
      st_nxt.powerup = 1'h0;
    end
    if (!i_fet_limit.high_side[0]) begin
      st_nxt.limit_run = 8'h0;
    end else if (st_r.limit_run <= 8'(OCP_CYCLES)) begin
      st_nxt.limit_run = st_r.limit_run + 8'h1;
    end
    if (i_sys_rst || i_core_rst) begin
      st_nxt = '{powerup: 1'h1, limit_run: 8'h0};
    end
  end
  always_ff @(posedge i_mclk) begin
    st_r <= st_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin tracks summary
  AST_PIN_IS_SUMMARY: assert property (o_fault_out_n_oe == !o_flags.summary_fault_flag)
    else $error("fault pin and summary flag disagree");
  AST_LOCKOUT_OFF: assert property (i_supply_low
    |=> o_bridge_enable == 2'h0 && !o_pump_enable)
    else $error("bridges or pump active in supply lockout");
  AST_LOCKOUT_FLAGS: assert property (i_supply_low && !st_r.powerup
    |=> o_flags.supply_low_lockout_flag && o_flags.summary_fault_flag)
    else $error("lockout flags missing");
  AST_CORE_RESET: assert property (disable iff (i_sys_rst)
    i_core_rst |=> o_flags == FLAGS_RESET && o_fault_out_n_oe)
    else $error("core reset left flags or pin active");
  AST_PUMP_LOW: assert property (i_pump_low
    |=> o_flags.pump_low_flag && !o_fault_out_n_oe && o_bridge_enable == 2'h0)
    else $error("pump undervoltage not reported");
  AST_PUMP_LATCH: assert property (o_flags.pump_low_flag && !i_clear_faults_cmd
    && !(i_sleep_n_input && !$past(i_sleep_n_input)) |=> o_flags.pump_low_flag)
    else $error("pump flag dropped without clear");
  AST_CLEAR_DROPS: assert property (i_clear_faults_cmd && !i_pump_low && !i_supply_low
    |=> !o_flags.pump_low_flag && !o_flags.supply_low_lockout_flag)
    else $error("clear left a flag whose cause ended");
  AST_OCP_TRIP: assert property (st_r.limit_run == 8'(OCP_CYCLES + 1)
    |-> ##[1:3] o_flags.overcurrent_flag && o_flags.highside_short_flag[0] && !o_bridge_enable[0])
    else $error("persistent limit did not trip");
endmodule : driver_fault_supervisor_checker

bind driver_fault_supervisor driver_fault_supervisor_checker #(.OCP_CYCLES(OCP_CYCLES)) i_chk (
  .i_mclk, .i_sys_rst, .i_core_rst, .i_supply_low, .i_pump_low, .i_fet_limit,
  .i_clear_faults_cmd, .i_sleep_n_input, .o_fault_out_n_oe, .o_flags, .o_bridge_enable,
  .o_pump_enable
);

/* File: tb_driver_fault_supervisor.sv */
// self-checking bench for the driver fault supervisor
`timescale 1ns/10ps
module tb_driver_fault_supervisor;
  import fault_sup_pkg::*;
  // short counts keep the run brief
  localparam int unsigned RET = 20;
  localparam int unsigned OPN = 16;
  localparam int unsigned OCPC = 4;
  logic i_mclk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_core_rst = 1'h0;
  logic i_supply_low = 1'h1;
  logic i_pump_low = 1'h0;
  fet_limit_s i_fet_limit = '0;
  logic [NUM_BRIDGES-1:0] i_winding_low = '0;
  logic i_open_winding_detect_enable = 1'h0;
  logic i_overcurrent_recovery_select = OVERCURRENT_RECOVERY_SELECT_LATCHED;
  logic clear_req = 1'h0;
  logic sleep_req = 1'h0;
  logic clear_cmd, sleep_n, fault_line;
  logic o_fault_out_n, o_fault_out_n_oe, o_fault_line_low, o_pump_enable;
  logic [NUM_BRIDGES-1:0] o_bridge_enable;
  fault_flags_s o_flags;
  fault_flags_s exp;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] lfsr_r = 32'ha16b;
  always #20 i_mclk = ~i_mclk;
  driver_fault_supervisor #(.RETRY_CYCLES(RET), .OPEN_DET_CYCLES(OPN), .OCP_CYCLES(OCPC)) i_dut (
    .i_mclk, .i_sys_rst, .i_core_rst, .i_supply_low, .i_pump_low, .i_fet_limit,
    .i_winding_low, .i_open_winding_detect_enable, .i_overcurrent_recovery_select,
    .i_clear_faults_cmd(clear_cmd), .i_sleep_n_input(sleep_n), .i_fault_out_n_in(fault_line),
    .o_fault_out_n, .o_fault_out_n_oe, .o_fault_line_low, .o_flags, .o_bridge_enable,
    .o_pump_enable
  );
  host_ctrl_model i_host (
    .i_mclk, .i_fault_out_n(o_fault_out_n), .i_fault_out_n_oe(o_fault_out_n_oe),
    .i_clear_req(clear_req), .i_sleep_req(sleep_req), .o_fault_line(fault_line),
    .o_clear_faults_cmd(clear_cmd), .o_sleep_n_input(sleep_n)
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // bridges still enabled once the bridge of one output has tripped
  function automatic logic [NUM_BRIDGES-1:0] bridge_mask(input int out_idx);
    return ~(NUM_BRIDGES'(1) << (out_idx / OUTS_PER_BRIDGE));
  endfunction : bridge_mask
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    tests_run++;
    if (seen !== expv) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  // settle at the falling edge so registered outputs have landed
  task automatic look(input int n);
    cyc(n);
    @(negedge i_mclk);
  endtask : look
  task automatic st(input fault_flags_s e, input logic [1:0] br);
    chk(o_flags, e);
    chk(fault_line, !e.summary_fault_flag);
    chk(o_bridge_enable, br);
  endtask : st
  task automatic host_evt(input logic use_sleep);
    cyc(1);
    sleep_req <= use_sleep;
    clear_req <= !use_sleep;
    cyc(1);
    sleep_req <= 1'h0;
    clear_req <= 1'h0;
    look(6);
  endtask : host_evt
  task automatic report_and_stop;
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin : watchdog
    cyc(30000);
    failures++;
    report_and_stop();
  end
  initial begin : main
    logic r;
    logic prev;
    r = 1'h0;
    cyc(10);
    i_sys_rst <= 1'h0;
    look(3);
    exp = FLAGS_RESET;
    exp.summary_fault_flag = 1'h1;
    st(exp, 2'h0);
    chk(o_fault_line_low, 1'h1);
    cyc(1);
    i_supply_low <= 1'h0;
    look(3);
    st(FLAGS_RESET, 2'h3);
    chk(o_fault_line_low, 1'h0);
    chk(o_pump_enable, 1'h1);
    cyc(1);
    i_supply_low <= 1'h1;
    look(3);
    exp.supply_low_lockout_flag = 1'h1;
    st(exp, 2'h0);
    chk(o_pump_enable, 1'h0);
    cyc(1);
    i_supply_low <= 1'h0;
    look(3);
    exp.summary_fault_flag = 1'h0;
    st(exp, 2'h3);
    cyc(1);
    i_core_rst <= 1'h1;
    look(2);
    st(FLAGS_RESET, 2'h0);
    cyc(1);
    i_core_rst <= 1'h0;
    i_pump_low <= 1'h1;
    look(4);
    exp = FLAGS_RESET;
    exp.summary_fault_flag = 1'h1;
    exp.pump_low_flag = 1'h1;
    st(exp, 2'h0);
    chk(o_pump_enable, 1'h1);
    host_evt(1'h0);
    st(exp, 2'h0);
    cyc(1);
    i_pump_low <= 1'h0;
    look(2);
    exp.summary_fault_flag = 1'h0;
    st(exp, 2'h3);
    host_evt(1'h0);
    st(FLAGS_RESET, 2'h3);
    // each FET limit, recovered by clear and sleep exit in turn
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      i_fet_limit <= fet_limit_s'(8'h1 << i);
      look(OCPC + 4);
      exp = FLAGS_RESET;
      exp.summary_fault_flag = 1'h1;
      exp.overcurrent_flag = 1'h1;
      {exp.highside_short_flag, exp.lowside_short_flag} = 8'h1 << i;
      st(exp, bridge_mask(i % 4));
      cyc(1);
      i_fet_limit <= '0;
      look(4);
      st(exp, bridge_mask(i % 4));
      host_evt(i[0]);
      st(FLAGS_RESET, 2'h3);
    end
    cyc(1);
    i_overcurrent_recovery_select <= OVERCURRENT_RECOVERY_SELECT_RETRY;
    i_fet_limit <= fet_limit_s'(8'h40);
    look(OCPC + 4);
    exp = FLAGS_RESET;
    exp.summary_fault_flag = 1'h1;
    exp.overcurrent_flag = 1'h1;
    exp.highside_short_flag = 4'h4;
    cyc(1);
    i_fet_limit <= '0;
    look(2);
    st(exp, bridge_mask(2));
    look(RET + 4);
    exp.summary_fault_flag = 1'h0;
    st(exp, 2'h3);
    host_evt(1'h0);
    st(FLAGS_RESET, 2'h3);
    cyc(1);
    i_winding_low <= 2'h1;
    look(OPN + 6);
    st(FLAGS_RESET, 2'h3);
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      i_open_winding_detect_enable <= 1'h1;
      i_winding_low <= 2'h1 << k;
      look(OPN - 1);
      chk(o_flags, FLAGS_RESET);
      look(5);
      exp = FLAGS_RESET;
      exp.summary_fault_flag = 1'h1;
      exp.open_winding_flag = 1'h1;
      exp.open_winding_a_flag = (k == 0);
      exp.open_winding_b_flag = (k == 1);
      chk(o_flags, exp);
      chk(fault_line, 1'h0);
      cyc(1);
      i_winding_low <= '0;
      look(3);
      chk(o_flags, exp);
      host_evt(k[0]);
      chk(o_flags, FLAGS_RESET);
      chk(fault_line, 1'h1);
    end
    for (int n = 0; n < 200; n++) begin
      cyc(1);
      lfsr_r = lfsr_next(lfsr_r);
      prev = r;
      r = lfsr_r[0];
      i_pump_low <= r;
      @(negedge i_mclk);
      chk(o_flags.summary_fault_flag, prev);
    end
    report_and_stop();
  end
endmodule : tb_driver_fault_supervisor
